// ---- logic/shadow_force_cfg.svh ----
// constants for the configuration shadow and floppy force registers
`ifndef SHADOW_FORCE_CFG_SVH
`define SHADOW_FORCE_CFG_SVH

// ============================================================
// configuration indexes
`define IDX_SERIAL1_SHADOW 8'h15
`define IDX_SERIAL2_SHADOW 8'h16
`define IDX_FLOPPY_FORCE 8'h17

// ============================================================
// reset values
`define SERIAL_SHADOW_RESET 8'h00
`define FLOPPY_FORCE_RESET 8'h03

// ============================================================
// fifo control field positions
`define FCR_FIFO_EN_BIT 0
`define FCR_RX_CLEAR_BIT 1
`define FCR_TX_CLEAR_BIT 2
`define FCR_DMA_SEL_BIT 3
`define FCR_TRIG_LSB 6
`define FCR_TRIG_MSB 7
// bits kept in the shadow; self-clearing and reserved bits read zero
`define FCR_KEEP_MASK 8'hC9

// ============================================================
// receive trigger levels in bytes
`define TRIG_LEVEL_00 4'h1
`define TRIG_LEVEL_01 4'h4
`define TRIG_LEVEL_10 4'h8
`define TRIG_LEVEL_11 4'hE

// ============================================================
// floppy force field positions
`define FORCE_CHG0_BIT 0
`define FORCE_CHG1_BIT 1
`define FORCE_WP_BIT 2
`define FORCE_KEEP_MASK 8'h07

`endif

// ---- logic/shadow_force_pkg.sv ----
// types shared by the configuration shadow and floppy force logic
`default_nettype none
package shadow_force_pkg;

  // ============================================================
  // fifo control value as written to a serial port
  typedef struct packed {
    logic [1:0] rx_trigger;
    logic [1:0] reserved;
    logic dma_select;
    logic tx_clear;
    logic rx_clear;
    logic fifo_enable;
  } fifo_ctrl_s;

  // ============================================================
  // one set of floppy interface signals, all active low
  typedef struct packed {
    logic drive_select0_n;
    logic drive_select1_n;
    logic head_step_n;
    logic disk_change_in_n;
    logic write_protect_in_n;
  } floppy_pins_s;

  // ============================================================
  // per-port fifo controls driven toward a serial port
  typedef struct packed {
    logic fifo_enable;
    logic rx_clear;
    logic tx_clear;
    logic dma_select;
    logic [3:0] rx_trigger_bytes;
  } fifo_cmd_s;

endpackage
`default_nettype wire

// ---- logic/fifo_ctrl_shadow.sv ----
// readable shadow and decoded controls of one serial fifo control register
`timescale 1ns/1ps
`default_nettype none
`include "shadow_force_cfg.svh"

module fifo_ctrl_shadow (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // write sources
  input wire logic runtime_wr,
  input wire logic cfg_wr,
  input wire logic [7:0] wdata,
  // results
  output logic [7:0] shadow,
  output shadow_force_pkg::fifo_cmd_s cmd
);

  logic [7:0] shadow_reg;
  logic [7:0] shadow_next;
  shadow_force_pkg::fifo_cmd_s cmd_reg;
  shadow_force_pkg::fifo_cmd_s cmd_next;
  shadow_force_pkg::fifo_ctrl_s wr_val;
  logic any_wr;

  assign wr_val = shadow_force_pkg::fifo_ctrl_s'(wdata);
  assign any_wr = runtime_wr | cfg_wr;

  // ============================================================
  // next state: store kept bits, pulse the clears for one cycle
  always_comb begin
    shadow_next = shadow_reg;
    cmd_next = cmd_reg;
    cmd_next.rx_clear = 1'b0;
    cmd_next.tx_clear = 1'b0;
    if (any_wr) begin
      // same-cycle copy; clear bits never stored so they read zero
      shadow_next = wdata & `FCR_KEEP_MASK;
      cmd_next.fifo_enable = wr_val.fifo_enable;
      cmd_next.rx_clear = wr_val.rx_clear;
      cmd_next.tx_clear = wr_val.tx_clear;
      // also passed to the port in the command; the port ignores it
      cmd_next.dma_select = wr_val.dma_select;
      unique case (wr_val.rx_trigger)
        2'b00: cmd_next.rx_trigger_bytes = `TRIG_LEVEL_00;
        2'b01: cmd_next.rx_trigger_bytes = `TRIG_LEVEL_01;
        2'b10: cmd_next.rx_trigger_bytes = `TRIG_LEVEL_10;
        2'b11: cmd_next.rx_trigger_bytes = `TRIG_LEVEL_11;
      endcase
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= `SERIAL_SHADOW_RESET;
      cmd_reg <= '{fifo_enable: 1'b0, rx_clear: 1'b0, tx_clear: 1'b0,
                   dma_select: 1'b0, rx_trigger_bytes: `TRIG_LEVEL_00};
    end else if (clk_en) begin
      shadow_reg <= shadow_next;
      cmd_reg <= cmd_next;
    end
  end

  assign shadow = shadow_reg;
  assign cmd = cmd_reg;

endmodule // fifo_ctrl_shadow
`default_nettype wire

// ---- logic/config_shadow_force_regs.sv ----
// configuration shadows of serial fifo control and floppy force register
// How it works
// - the first serial shadow is reached only in configuration state with index 0x15 loaded.
// - bits 7:6, 3 and 0 written to the first serial port's fifo control register are kept readable in its shadow.
// - fifo control bit 0 set enables both the transmit and receive fifos.
// - writing one to bit 1 empties the receive fifo and zeroes its counters, then the bit clears itself.
// - writing one to bit 2 empties the transmit fifo and zeroes its counters, then the bit clears itself.
// - bit 3, the dma select, changes nothing in the serial port.
// - reserved bits read zero and ignore writes: bits 5:4 of the shadows and 7:3 of the force register.
// - bits 7:6 pick the receive trigger level of 1, 4, 8 or 14 bytes.
// - the second serial port has an identical shadow reached only in configuration state at index 0x16.
// - the force register is reached only in configuration state at index 0x17 and resets to 0x03.
// - a set force-change bit shows disk change active while its drive is selected.
// - software can only set the force-change bits; writing zero leaves them as they are.
// - step with drive select 0 clears force-change bit 0, step with drive select 1 clears bit 1.
// - the digital input disk-change flag is the pin OR each select combined with its force bit.
// - force write protect with any drive selected asserts the controller write-protect input.
// - the force controls act the same on the floppy pins and on the floppy-over-parallel-port pins.
`timescale 1ns/1ps
`default_nettype none
`include "shadow_force_cfg.svh"

module config_shadow_force_regs #(
  parameter int NUM_SERIAL = 2
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration data port
  input wire logic config_state,
  input wire logic [7:0] config_index_reg,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_hit,
  // run-time fifo control writes, one strobe per serial port
  input wire logic [NUM_SERIAL-1:0] fifo_control_wr,
  input wire logic [7:0] fifo_control_wdata,
  output shadow_force_pkg::fifo_cmd_s [NUM_SERIAL-1:0] fifo_cmd,
  // floppy signals from the dedicated pins and the parallel port pins
  input wire shadow_force_pkg::floppy_pins_s fdd_pins,
  input wire shadow_force_pkg::floppy_pins_s pp_pins,
  input wire logic floppy_on_pport,
  // effective inputs seen by the floppy controller
  output logic ctl_disk_change_n,
  output logic ctl_write_protect_n,
  output logic dir_disk_change
);

  // ============================================================
  // elaboration checks
  // index mapping only covers two consecutive serial shadows
  if (NUM_SERIAL != 2) begin : g_bad_num_serial
    $error("config_shadow_force_regs supports exactly two serial ports");
  end

  // ============================================================
  // configuration decode
  logic sel_force;
  logic [NUM_SERIAL-1:0] sel_serial;
  logic [7:0] serial_shadow [NUM_SERIAL];

  assign sel_force = config_state &&
                     (config_index_reg == `IDX_FLOPPY_FORCE);

  // ============================================================
  // serial shadows, one instance per port
  for (genvar i = 0; i < NUM_SERIAL; i++) begin : g_serial
    localparam logic [7:0] IDX = (i == 0) ? `IDX_SERIAL1_SHADOW
                                          : `IDX_SERIAL2_SHADOW;
    // access gated by configuration state and the loaded index
    assign sel_serial[i] = config_state &&
                           (config_index_reg == IDX);

    fifo_ctrl_shadow u_shadow (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .runtime_wr(fifo_control_wr[i]),
      .cfg_wr(cfg_wr & sel_serial[i]),
      .wdata(cfg_wr & sel_serial[i] ? cfg_wdata : fifo_control_wdata),
      .shadow(serial_shadow[i]),
      .cmd(fifo_cmd[i])
    );
  end

  // ============================================================
  // effective floppy signals from whichever pin set is active
  // both pin sets go through the same force logic below
  shadow_force_pkg::floppy_pins_s pins;
  logic drive0_sel;
  logic drive1_sel;
  logic step_act;

  assign pins = floppy_on_pport ? pp_pins : fdd_pins;
  assign drive0_sel = ~pins.drive_select0_n;
  assign drive1_sel = ~pins.drive_select1_n;
  assign step_act = ~pins.head_step_n;

  // ============================================================
  // force register state
  logic force_change_drive0_reg;
  logic force_change_drive0_next;
  logic force_change_drive1_reg;
  logic force_change_drive1_next;
  logic force_write_protect_reg;
  logic force_write_protect_next;
  logic force_wr;

  assign force_wr = cfg_wr & sel_force;

  // hardware clear first; a software set in the same cycle wins so
  // a freshly requested forced change is never lost
  always_comb begin
    force_change_drive0_next = force_change_drive0_reg;
    force_change_drive1_next = force_change_drive1_reg;
    force_write_protect_next = force_write_protect_reg;
    if (step_act && drive0_sel) begin
      force_change_drive0_next = 1'b0;
    end
    if (step_act && drive1_sel) begin
      force_change_drive1_next = 1'b0;
    end
    if (force_wr) begin
      // zero writes leave the force-change bits alone
      if (cfg_wdata[`FORCE_CHG0_BIT]) begin
        force_change_drive0_next = 1'b1;
      end
      if (cfg_wdata[`FORCE_CHG1_BIT]) begin
        force_change_drive1_next = 1'b1;
      end
      force_write_protect_next = cfg_wdata[`FORCE_WP_BIT];
    end
  end

  localparam logic [7:0] FORCE_RST = `FLOPPY_FORCE_RESET;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_change_drive0_reg <= FORCE_RST[`FORCE_CHG0_BIT];
      force_change_drive1_reg <= FORCE_RST[`FORCE_CHG1_BIT];
      force_write_protect_reg <= FORCE_RST[`FORCE_WP_BIT];
    end else if (clk_en) begin
      force_change_drive0_reg <= force_change_drive0_next;
      force_change_drive1_reg <= force_change_drive1_next;
      force_write_protect_reg <= force_write_protect_next;
    end
  end

  // ============================================================
  // forced floppy inputs; combinational so the pin path adds no delay
  logic disk_change_flag;

  assign disk_change_flag = ~pins.disk_change_in_n
                          | (drive0_sel & force_change_drive0_reg)
                          | (drive1_sel & force_change_drive1_reg);
  assign dir_disk_change = disk_change_flag;
  assign ctl_disk_change_n = ~disk_change_flag;
  assign ctl_write_protect_n = pins.write_protect_in_n &
      ~(force_write_protect_reg & (drive0_sel | drive1_sel));

  // ============================================================
  // read-back: reserved bits are set to zero and masked off
  logic [7:0] force_view;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic hit_now;

  always_comb begin
    force_view = 8'h00;
    force_view[`FORCE_CHG0_BIT] = force_change_drive0_reg;
    force_view[`FORCE_CHG1_BIT] = force_change_drive1_reg;
    force_view[`FORCE_WP_BIT] = force_write_protect_reg;
    force_view = force_view & `FORCE_KEEP_MASK;
  end

  assign hit_now = sel_force | (|sel_serial);

  // unmatched indexes read zero so other banks can be ORed in
  always_comb begin
    rdata_next = rdata_reg;
    if (cfg_rd) begin
      rdata_next = 8'h00;
      if (sel_force) begin
        rdata_next = force_view;
      end
      for (int i = 0; i < NUM_SERIAL; i++) begin
        if (sel_serial[i]) begin
          rdata_next = serial_shadow[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_hit = hit_now;

endmodule // config_shadow_force_regs
`default_nettype wire

// ---- testbench/shadow_force_monitor.sv ----
// assertion checker for the configuration shadow and floppy force block
`timescale 1ns/1ps
`default_nettype none

module shadow_force_monitor #(
  parameter int NUM_SERIAL = 2
) (
  // clock and configuration port
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic config_state,
  input wire logic [7:0] config_index_reg,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_hit,
  // fifo control
  input wire logic [NUM_SERIAL-1:0] fifo_control_wr,
  input wire logic [7:0] fifo_control_wdata,
  input wire shadow_force_pkg::fifo_cmd_s [NUM_SERIAL-1:0] fifo_cmd,
  // floppy
  input wire shadow_force_pkg::floppy_pins_s fdd_pins,
  input wire shadow_force_pkg::floppy_pins_s pp_pins,
  input wire logic floppy_on_pport,
  input wire logic ctl_disk_change_n,
  input wire logic ctl_write_protect_n,
  input wire logic dir_disk_change
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // helpers; a coinciding config write is left out since it wins
  shadow_force_pkg::floppy_pins_s p;
  assign p = floppy_on_pport ? pp_pins : fdd_pins;
  sequence s_wr0;
    clk_en && fifo_control_wr[0] && !cfg_wr;
  endsequence
  sequence s_step0;
    clk_en && !p.head_step_n && !p.drive_select0_n && !cfg_wr;
  endsequence
  function automatic logic [3:0] lvl(input logic [1:0] c);
    return c == 2'h0 ? 4'h1 : c == 2'h1 ? 4'h4 : c == 2'h2 ? 4'h8 : 4'hE;
  endfunction
  // ==========================================
  // assertions
  a_hit_decode: assert property (
    cfg_hit == (config_state && config_index_reg inside {8'h15, 8'h16, 8'h17}))
    else $error("hit decode wrong");
  a_miss_reads_zero: assert property (
    cfg_rd && clk_en && !cfg_hit |=> cfg_rdata == 8'h00)
    else $error("refused read not zero");
  a_enable_follows: assert property (
    s_wr0 |=> fifo_cmd[0].fifo_enable == $past(fifo_control_wdata[0]))
    else $error("fifo enable wrong");
  a_clear_pulse: assert property (
    s_wr0 |=> fifo_cmd[0].rx_clear == $past(fifo_control_wdata[1])
      && fifo_cmd[0].tx_clear == $past(fifo_control_wdata[2]))
    else $error("clear pulse wrong");
  a_clear_self: assert property (
    (fifo_cmd[0].rx_clear || fifo_cmd[0].tx_clear) && clk_en
      && !fifo_control_wr[0] && !cfg_wr
      |=> !fifo_cmd[0].rx_clear && !fifo_cmd[0].tx_clear)
    else $error("clear not self clearing");
  a_trigger_level: assert property (
    s_wr0 |=> fifo_cmd[0].rx_trigger_bytes == lvl($past(fifo_control_wdata[7:6])))
    else $error("trigger level wrong");
  a_change_inverse: assert property (
    ctl_disk_change_n == !dir_disk_change)
    else $error("disk change outputs disagree");
  a_idle_passthru: assert property (
    p.drive_select0_n && p.drive_select1_n |-> dir_disk_change ==
      !p.disk_change_in_n && ctl_write_protect_n == p.write_protect_in_n)
    else $error("force acts without selection");
  a_step_clears: assert property (
    s_step0 ##1 (!p.drive_select0_n && p.drive_select1_n && p.disk_change_in_n)
      |-> !dir_disk_change)
    else $error("step did not clear force");
endmodule // shadow_force_monitor

bind config_shadow_force_regs shadow_force_monitor #(
  .NUM_SERIAL(NUM_SERIAL)
) i_shadow_force_monitor (
  .ref_clk, .rst_n, .clk_en, .config_state, .config_index_reg, .cfg_wr,
  .cfg_rd, .cfg_rdata, .cfg_hit, .fifo_control_wr, .fifo_control_wdata,
  .fifo_cmd, .fdd_pins, .pp_pins, .floppy_on_pport, .ctl_disk_change_n,
  .ctl_write_protect_n, .dir_disk_change
);
`default_nettype wire

// ---- testbench/config_shadow_force_regs_bench.sv ----
// self-checking bench for the configuration shadow and floppy force block
`timescale 1ns/1ps
`default_nettype none

module config_shadow_force_regs_bench;
  // ==========================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic config_state = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic floppy_on_pport = 1'b0;
  logic [7:0] config_index_reg = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] fifo_control_wdata = 8'h00;
  logic [1:0] fifo_control_wr = 2'h0;
  shadow_force_pkg::floppy_pins_s fdd_pins = 5'h1F;
  shadow_force_pkg::floppy_pins_s pp_pins = 5'h1F;
  logic [7:0] cfg_rdata;
  logic cfg_hit, ctl_disk_change_n, ctl_write_protect_n, dir_disk_change;
  shadow_force_pkg::fifo_cmd_s [1:0] fifo_cmd;
  logic [3:0] trig [4] = '{4'h1, 4'h4, 4'h8, 4'hE};
  logic [1:0] code;
  logic p;
  int failures = 0;
  int comparisons = 0;

  always #25 ref_clk = ~ref_clk;

  config_shadow_force_regs #(.NUM_SERIAL(2)) i_config_shadow_force_regs (
    .ref_clk, .rst_n, .clk_en, .config_state, .config_index_reg, .cfg_wr,
    .cfg_rd, .cfg_wdata, .cfg_rdata, .cfg_hit, .fifo_control_wr,
    .fifo_control_wdata, .fifo_cmd, .fdd_pins, .pp_pins, .floppy_on_pport,
    .ctl_disk_change_n, .ctl_write_protect_n, .dir_disk_change
  );

  // ==========================================
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // returns 1 ns after the edge so inputs set next move clear of it
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // trailing tick keeps a strobe from being raised twice in one step
  task automatic cfg_access(input logic [7:0] idx, input logic [7:0] d,
                            input logic rd);
    config_index_reg = idx;
    cfg_wdata = d;
    cfg_rd = rd;
    cfg_wr = !rd;
    tick();
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    cfg_access(idx, 8'h00, 1'b1);
    check(cfg_rdata, exp);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    tick();
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h03);
    // every trigger code on both ports, bits 5:1 written as one, bit 0 as the low code bit
    for (int i = 0; i < 8; i++) begin
      code = i[1:0];
      p = i[2];
      fifo_control_wdata = {code, 5'h1F, code[0]};
      fifo_control_wr[p] = 1'b1;
      tick();
      fifo_control_wr = 2'h0;
      check(fifo_cmd[p], {code[0], 3'h7, trig[code]});
      tick();
      check(fifo_cmd[p], {code[0], 3'h1, trig[code]});
      rd(8'h15 + 8'(p), {code, 5'h04, code[0]});
    end
    // writes outside configuration state or at a foreign index
    config_state = 1'b0;
    cfg_access(8'h15, 8'h00, 1'b0);
    rd(8'h17, 8'h00);
    config_state = 1'b1;
    cfg_access(8'h14, 8'h00, 1'b0);
    rd(8'h15, 8'hC9);
    // a configuration write acts like a run-time fifo control write
    cfg_access(8'h16, 8'h41, 1'b0);
    check(fifo_cmd[1], 8'h84);
    rd(8'h16, 8'h41);
    // clock enable low freezes the shadow against a run-time write
    clk_en = 1'b0;
    fifo_control_wdata = 8'h00;
    fifo_control_wr = 2'h1;
    tick();
    fifo_control_wr = 2'h0;
    clk_en = 1'b1;
    rd(8'h15, 8'hC9);
    // forced change on the dedicated pins, then a step on drive zero
    fdd_pins.drive_select0_n = 1'b0;
    #1;
    check(dir_disk_change, 1'b1);
    check(ctl_disk_change_n, 1'b0);
    fdd_pins.head_step_n = 1'b0;
    tick();
    fdd_pins.head_step_n = 1'b1;
    #1;
    check(dir_disk_change, 1'b0);
    rd(8'h17, 8'h02);
    // same controls through the parallel port pins on drive one
    fdd_pins = 5'h1F;
    floppy_on_pport = 1'b1;
    pp_pins.drive_select1_n = 1'b0;
    #1;
    check(dir_disk_change, 1'b1);
    cfg_access(8'h17, 8'hFF, 1'b0);
    rd(8'h17, 8'h07);
    check(ctl_write_protect_n, 1'b0);
    pp_pins = 5'h1D;
    #1;
    check(dir_disk_change, 1'b1);
    check(ctl_write_protect_n, 1'b1);
    pp_pins = 5'h11;
    tick();
    pp_pins = 5'h17;
    #1;
    check(dir_disk_change, 1'b0);
    cfg_access(8'h17, 8'h00, 1'b0);
    rd(8'h17, 8'h01);
    // reset in mid-run brings back the power-on values
    rst_n = 1'b0;
    tick();
    rst_n = 1'b1;
    tick();
    rd(8'h17, 8'h03);
    rd(8'h16, 8'h00);
    tick();
    give_verdict();
  end

  // the tests need under 200 cycles; this cuts a hang short
  initial begin
    #(2000 * 50);
    failures++;
    give_verdict();
  end
endmodule // config_shadow_force_regs_bench
`default_nettype wire
